//--- coord_set_chk.sv
// Port checker for the coordinate-setting block.
// Bound to coordinate_set_command, sees its ports only.
`timescale 1ns/10ps
`include "coord_set_consts.vh"
module coord_set_chk (
    // Bus
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    // NVM and state
    input wire nvmWrReq,
    input wire [31:0] nvmWrData,
    input wire nvmWrAck,
    input wire homedOut,
    input wire limitsEnOut,
    input wire [31:0] homeOffsetOut
);
    wire ctrlWr = psel && penable && pwrite && paddr == `OFS_CTRL;
    wire nvmWait = nvmWrReq && !nvmWrAck;
    // ====================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no pready");
    property p_phase; pready |-> psel && penable; endproperty
    a_phase: assert property (p_phase) else $error("stray pready");
    property p_ro; pwrite && pready && paddr == `OFS_STATUS |-> pslverr;
    endproperty
    a_ro: assert property (p_ro) else $error("read-only write taken");
    property p_hold; nvmWait |=> nvmWrReq; endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_stab; nvmWait |=> $stable(nvmWrData); endproperty
    a_stab: assert property (p_stab) else $error("data moved");
    property p_cause; $rose(nvmWrReq) |-> $past(ctrlWr); endproperty
    a_cause: assert property (p_cause) else $error("stray write");
    property p_lim; $rose(limitsEnOut) |-> homedOut; endproperty
    a_lim: assert property (p_lim) else $error("limits unhomed");
    property p_rst; $fell(rst) |-> !nvmWrReq && !homedOut && !limitsEnOut
        && homeOffsetOut == 32'h00000000; endproperty
    a_rst: assert property (p_rst) else $error("state kept");
    c_nvm: cover property ($rose(nvmWrReq));
    c_homed: cover property ($rose(homedOut));
    c_err: cover property (pslverr);
endmodule
bind coordinate_set_command coord_set_chk coord_set_chk_i (.*);

//--- coord_set_consts.vh
// Constants for the coordinate-setting command block.
// Assumes a 100 MHz clk_sys and an APB master with 32-bit data.
// Notes on behaviour
// RL1: Value signed, within plus/minus 99,999,999 units.
// RL2: Incremental: supplied value becomes new home.
// RL3: Incremental: homing done, soft limits enabled.
// RL4: Incremental: setting lost on power-off or restart.
// RL5: Incremental: stored home parameter left unchanged.
// RL6: Incremental: restart reloads stored home after homing.
// RL7: Absolute: position set, home offset parameter rewritten.
// RL8: Absolute: setting survives power-off and restart.
// RL9: Absolute: each command writes parameter to NVM.
// RL10: Host issues command rarely, sparing NVM.
// RL11: Host restarts after gearing/limit changes first.
// RL12: Host checks reference before starting motion.
// RL13: Out-of-range value rejected, coordinates kept.
`ifndef COORD_SET_CONSTS_VH
`define COORD_SET_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL 12'h000
`define OFS_VALUE 12'h004
`define OFS_STATUS 12'h008
`define OFS_HOME_PARAM 12'h00C
`define OFS_HOME_CUR 12'h010
`define OFS_POSITION 12'h014
`define OFS_OFFSET 12'h018

// ==========================================================
// Control register fields
`define CTRL_EXEC_BIT 0
`define CTRL_RESTART_BIT 1
`define CTRL_ABS_BIT 2
`define CTRL_HOMED_BIT 3

// ==========================================================
// Status register fields
`define ST_HOMED_BIT 0
`define ST_LIMITS_BIT 1
`define ST_OK_BIT 2
`define ST_ERR_BIT 3
`define ST_BUSY_BIT 4

// ==========================================================
// Range and reset values
`define COORD_MAX 32'h05F5E0FF
`define COORD_MIN 32'hFA0A1F01
`define HOME_PARAM_RST 32'h00000000
`define UNMAPPED_DATA 32'h00000000

`endif

//--- coordinate_set_command.v
// Coordinate-setting command interpreter with an APB register slave.
// Assumes an external NVM writer handshaking on nvmWrReq/nvmWrAck and a
// motion core supplying the current raw encoder position.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "coord_set_consts.vh"

module coordinate_set_command (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Position core
    input wire [31:0] rawPosition,
    input wire homingDone,
    // Non-volatile store of the home parameter
    output reg nvmWrReq,
    output reg [31:0] nvmWrData,
    input wire nvmWrAck,
    // State for the motion core
    output reg homedOut,
    output reg limitsEnOut,
    output reg [31:0] homeOffsetOut
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_NVM = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    // ==========================================================
    // Range check, used only by the command path for execCmd
    function inRange;
        input [31:0] v;
        begin
            inRange = ($signed(v) <= $signed(`COORD_MAX)) && // RL1
                ($signed(v) >= $signed(`COORD_MIN));
        end
    endfunction

    // ==========================================================
    // Offset that makes the position read target at this raw count
    function [31:0] offsetFor;
        input [31:0] target;
        input [31:0] raw;
        begin
            // Wraps modulo 2^32, as position itself does
            offsetFor = target - raw;
        end
    endfunction

    // ==========================================================
    // State registers
    reg [2:0] state_reg;
    reg [31:0] value_reg;
    reg absEnc_reg;
    reg homed_reg;
    reg limitsEn_reg;
    reg okFlag_reg;
    reg errFlag_reg;
    reg [31:0] homeParam_reg;
    reg [31:0] homeCur_reg;
    reg [31:0] offset_reg;

    // ==========================================================
    // Bus decode
    // A write lands in the access cycle, where pready is always high
    wire wrAcc = psel && penable && pwrite;
    wire ctrlWr = wrAcc && (paddr == `OFS_CTRL);
    // Exec ignored while busy so the NVM copy cannot change mid-write
    wire execCmd = ctrlWr && pwdata[`CTRL_EXEC_BIT] && (state_reg == ST_IDLE);
    wire restartCmd = ctrlWr && pwdata[`CTRL_RESTART_BIT];
    wire valOk = inRange(value_reg);
    wire [31:0] newOffset = offsetFor(value_reg, rawPosition);
    // Host-visible position is the raw count plus the offset
    wire [31:0] position = rawPosition + offset_reg;

    // ==========================================================
    // APB: single-cycle access, pready raised in the access phase
    always @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            // Zero wait states: pready answers the setup cycle
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            // Read data taken at setup so it stands through the access
            if (psel && !penable) begin
                case (paddr)
                    `OFS_CTRL:
                        prdata <= {28'h0000000, homed_reg, absEnc_reg,
                            2'b00};
                    `OFS_VALUE:
                        prdata <= value_reg;
                    `OFS_STATUS:
                        prdata <= {27'h0000000, (state_reg != ST_IDLE),
                            errFlag_reg, okFlag_reg, limitsEn_reg,
                            homed_reg};
                    `OFS_HOME_PARAM:
                        prdata <= homeParam_reg;
                    `OFS_HOME_CUR:
                        prdata <= homeCur_reg;
                    `OFS_POSITION:
                        prdata <= position;
                    `OFS_OFFSET:
                        prdata <= offset_reg;
                    default: begin
                        prdata <= `UNMAPPED_DATA;
                        pslverr <= !pwrite;
                    end
                endcase
                if (pwrite && paddr != `OFS_CTRL && paddr != `OFS_VALUE)
                    pslverr <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Command engine
    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            value_reg <= 32'h00000000;
            absEnc_reg <= 1'b0;
            homed_reg <= 1'b0;
            limitsEn_reg <= 1'b0;
            okFlag_reg <= 1'b0;
            errFlag_reg <= 1'b0;
            // Reset stands for the power-on load of the stored parameter
            homeParam_reg <= `HOME_PARAM_RST;
            homeCur_reg <= `HOME_PARAM_RST;
            offset_reg <= 32'h00000000;
            nvmWrReq <= 1'b0;
            nvmWrData <= 32'h00000000;
        end else begin
            if (wrAcc && paddr == `OFS_VALUE && state_reg == ST_IDLE)
                value_reg <= pwdata;
            if (ctrlWr && state_reg == ST_IDLE)
                absEnc_reg <= pwdata[`CTRL_ABS_BIT];
            if (restartCmd && state_reg == ST_IDLE) begin
                // Incremental coordinates are dropped; absolute kept
                if (!absEnc_reg) begin // RL8
                    homed_reg <= 1'b0; // RL4
                    limitsEn_reg <= 1'b0; // RL4
                    homeCur_reg <= homeParam_reg; // RL4
                    offset_reg <= 32'h00000000; // RL4
                end
            end
            // Homing completion reloads the stored home; placed after
            // the restart clear so a same-cycle completion still homes
            if (homingDone && !absEnc_reg) begin
                homeCur_reg <= homeParam_reg; // RL6
                homed_reg <= 1'b1; // RL6
                limitsEn_reg <= 1'b1; // RL6
            end
            case (state_reg)
                ST_IDLE: begin
                    if (execCmd) begin
                        okFlag_reg <= 1'b0;
                        errFlag_reg <= 1'b0;
                        if (!valOk) begin
                            errFlag_reg <= 1'b1; // RL13
                        end else if (!pwdata[`CTRL_ABS_BIT]) begin
                            homeCur_reg <= value_reg; // RL2 RL5
                            offset_reg <= newOffset; // RL2
                            homed_reg <= 1'b1; // RL3
                            limitsEn_reg <= 1'b1; // RL3
                            okFlag_reg <= 1'b1;
                        end else begin
                            // Offset chosen so position reads the value
                            offset_reg <= newOffset; // RL7
                            homeParam_reg <= newOffset; // RL7
                            homeCur_reg <= value_reg; // RL7
                            homed_reg <= 1'b1;
                            limitsEn_reg <= 1'b1;
                            // Same word goes to the live copy and the NVM
                            nvmWrData <= newOffset; // RL9
                            nvmWrReq <= 1'b1; // RL8 RL9
                            state_reg <= ST_NVM;
                        end
                    end
                end
                ST_NVM: begin
                    // Request and data held until the store acknowledges
                    if (nvmWrAck) begin
                        nvmWrReq <= 1'b0;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Busy stays up until ok is posted
                    okFlag_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    // A stray state must not leave a write hanging
                    nvmWrReq <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Registered copies for the motion core
    // Limitation: these lag the internal state by one cycle
    always @(posedge clk_sys) begin
        if (rst) begin
            homedOut <= 1'b0;
            limitsEnOut <= 1'b0;
            homeOffsetOut <= 32'h00000000;
        end else begin
            homedOut <= homed_reg;
            limitsEnOut <= limitsEn_reg;
            homeOffsetOut <= offset_reg;
        end
    end

endmodule

//--- nvm_model.sv
// NVM writer model: acks a held request ackDelay+1 cycles after it rises.
// Assumes the block holds request and data until the ack.
`timescale 1ns/10ps
module nvm_model (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Handshake with the block
    input wire nvmWrReq,
    output reg nvmWrAck,
    // Bench control and write counter
    input wire [3:0] ackDelay,
    output reg [7:0] writeCount
);
    reg [3:0] waitCnt;
    wire done = nvmWrReq && !nvmWrAck && waitCnt == ackDelay;
    // Reset is last so it wins over the updates above it
    always @(posedge clk_sys) begin
        waitCnt <= (nvmWrReq && !nvmWrAck && !done) ? waitCnt + 4'h1 : 4'h0;
        nvmWrAck <= done;
        if (done) writeCount <= writeCount + 8'h01;
        if (rst) {waitCnt, nvmWrAck, writeCount} <= '0;
    end
endmodule

//--- tb.sv
// Bench: APB tasks drive the block, an NVM model acks its writes.
// Assumes a 100 MHz clk_sys; waits on pready and busy, fixed counts only for reset and the homingDone pulse.
`timescale 1ns/10ps
`include "coord_set_consts.vh"
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin nErrors++; \
    $display("ERROR %0t: mismatch", $time); end end
module tb;
    logic clk_sys, rst, psel, penable, pwrite, homingDone, pready, pslverr;
    logic nvmWrReq, nvmWrAck, homedOut, limitsEnOut, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rawPosition, nvmWrData, homeOffsetOut, rd;
    logic [3:0] ackDelay;
    logic [7:0] writeCount;
    logic [31:0] vals [4] = '{`COORD_MAX + 32'h1, `COORD_MIN,
        `COORD_MIN - 32'h1, `COORD_MAX};
    logic [31:0] exps [4] = '{32'h000004D2, `COORD_MIN, `COORD_MIN,
        `COORD_MAX};
    logic [3:0] errs = 4'h5;
    int nErrors = 0;
    int checkCount = 0;
    coordinate_set_command coordinate_set_command_i (.*);
    nvm_model nvm_model_i (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1)
        if (pready !== 1'b1) report_and_stop();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
    endtask
    // Leaves the last STATUS word in rd
    task automatic exec(input logic [31:0] v, input logic ab);
        int n;
        n = 0;
        apb(1'b1, `OFS_VALUE, v);
        apb(1'b1, `OFS_CTRL, {29'h0, ab, 2'b01});
        do begin
            apb(1'b0, `OFS_STATUS, 32'h00000000);
            n++;
        end while (rd[`ST_BUSY_BIT] !== 1'b0 && n < 30);
        `CHK(rd[`ST_BUSY_BIT], 1'b0)
        if (rd[`ST_BUSY_BIT] !== 1'b0) report_and_stop();
    endtask
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, homingDone, paddr, pwdata} = '0;
        rawPosition = 32'h00000064;
        ackDelay = 4'h1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rdChk(`OFS_STATUS, 32'h00000000);
        rdChk(`OFS_HOME_PARAM, `HOME_PARAM_RST);
        $display("Test reset done");
        exec(32'h000004D2, 1'b0);
        `CHK(rd, 32'h00000007)
        `CHK({homedOut, limitsEnOut}, 2'b11)
        `CHK(homeOffsetOut, 32'h0000046E)
        `CHK(writeCount, 8'h00)
        rdChk(`OFS_HOME_CUR, 32'h000004D2);
        rdChk(`OFS_HOME_PARAM, `HOME_PARAM_RST);
        for (int i = 0; i < 4; i++) begin
            exec(vals[i], 1'b0);
            `CHK(rd[`ST_ERR_BIT], errs[i])
            rdChk(`OFS_HOME_CUR, exps[i]);
        end
        apb(1'b0, 12'h0FC, 32'h00000000);
        `CHK(er, 1'b1)
        apb(1'b1, `OFS_STATUS, 32'h00000000);
        `CHK(er, 1'b1)
        $display("Test range done");
        apb(1'b1, `OFS_CTRL, 32'h00000002);
        rdChk(`OFS_HOME_CUR, `HOME_PARAM_RST);
        `CHK({homedOut, limitsEnOut}, 2'b00)
        `CHK(homeOffsetOut, 32'h00000000)
        @(posedge clk_sys) homingDone <= 1'b1;
        @(posedge clk_sys) homingDone <= 1'b0;
        apb(1'b0, `OFS_STATUS, 32'h00000000);
        `CHK(rd[`ST_HOMED_BIT], 1'b1)
        $display("Test restart done");
        apb(1'b1, `OFS_CTRL, 32'h00000006);
        exec(32'h000001F4, 1'b1);
        rdChk(`OFS_HOME_PARAM, 32'h00000190);
        rdChk(`OFS_POSITION, 32'h000001F4);
        `CHK(homeOffsetOut, 32'h00000190)
        `CHK(nvmWrData, 32'h00000190)
        `CHK({nvmWrReq, writeCount}, 9'h001)
        ackDelay <= 4'h6;
        exec(32'h000003E8, 1'b1);
        `CHK(writeCount, 8'h02)
        apb(1'b1, `OFS_CTRL, 32'h00000006);
        rdChk(`OFS_POSITION, 32'h000003E8);
        rdChk(`OFS_HOME_PARAM, 32'h00000384);
        $display("Test absolute done");
        report_and_stop();
    end
endmodule
